// ---- logic/soft_output_map_pkg.sv ----
// Shared constants for the soft output status map
package soft_output_map_pkg;

  // Item counts
  localparam int NUM_OUTPUTS = 256;              // Soft outputs in total
  localparam int BASIC_OUTPUTS = 64;             // Outputs in the basic layout
  localparam int NUM_SOFT_INPUTS = 64;           // Soft inputs reached by coils
  localparam int NUM_RESET_CANCEL = 16;          // Reset/cancel-delay channels
  localparam int WORD_BITS = 16;                 // Width of one register word
  localparam int ASM_WORDS = 32;                 // Words in the extended assembly
  localparam int ASM_SEL_W = 5;                  // Assembly word index width

  // Network endpoint
  localparam logic [15:0] SERVER_TCP_PORT = 16'h01f6;  // Port 502
  localparam logic [7:0] UNIT_ID_REFUSED = 8'h00;      // Unit identifier never served

  // Function codes
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT_REG = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_REG = 8'h06;

  // Exception codes
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

  // Coil write values
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;

  // Register numbers
  localparam logic [15:0] REG_STATE_FIRST = 16'h0001;    // output_state_1_16
  localparam logic [15:0] REG_FAULT_LAST = 16'h0008;     // output_fault_49_64
  localparam logic [15:0] REG_SOFT_IN_FIRST = 16'h0009;  // soft_input_1_16
  localparam logic [15:0] REG_SOFT_IN_LAST = 16'h000b;   // soft_input_33_48

  // Discrete input numbers
  localparam logic [15:0] DI_BASIC_FIRST = 16'h2711;     // 10001
  localparam logic [15:0] DI_BASIC_LAST = 16'h2790;      // 10128
  localparam logic [15:0] DI_STATE_FIRST = 16'h2af9;     // 11001
  localparam logic [15:0] DI_STATE_LAST = 16'h2bf8;      // 11256
  localparam logic [15:0] DI_FAULT_FIRST = 16'h2ee1;     // 12001
  localparam logic [15:0] DI_FAULT_LAST = 16'h2fe0;      // 12256
  localparam logic [15:0] DI_FEEDBACK_FIRST = 16'h3a99;  // 15001
  localparam logic [15:0] DI_FEEDBACK_LAST = 16'h3aa8;   // 15016

  // Coil numbers
  localparam logic [15:0] COIL_BASIC_FIRST = 16'h0001;   // Legacy output/fault coils
  localparam logic [15:0] COIL_BASIC_LAST = 16'h0080;    // 128
  localparam logic [15:0] COIL_SOFT_IN_FIRST = 16'h0bb9; // 3001
  localparam logic [15:0] COIL_SOFT_IN_LAST = 16'h0bf8;  // 3064
  localparam logic [15:0] COIL_RESET_FIRST = 16'h0fa1;   // 4001
  localparam logic [15:0] COIL_RESET_LAST = 16'h0fb0;    // 4016

  // Feature revision that still offers legacy coils
  localparam logic [7:0] REV_LEGACY_COILS_MAX = 8'h01;

endpackage

// ---- logic/word_select.sv ----
`timescale 1ns/1ns
`default_nettype none
// Picks one 16-bit word out of a packed bit vector, word 0 in the low bits
module word_select #(
  parameter int WORDS = 8,
  parameter int SEL_W = 3
) (
  input wire logic [WORDS*16-1:0] vec_i,
  input wire logic [SEL_W-1:0] sel_i,
  output logic [15:0] word_o
);

  // Refuse an index too narrow for the word count
  if ((1 << SEL_W) < WORDS) begin : g_bad_sel
    $error("word_select: index too narrow");
  end

  // Out of range indices read as zero
  always_comb begin
    word_o = 16'h0000;
    if (32'(sel_i) < WORDS) begin
      word_o = vec_i[sel_i*16 +: 16];
    end
  end

endmodule // word_select
`default_nettype wire

// ---- logic/soft_output_map.sv ----
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Extended assembly carries all 256 outputs contiguously
// - Assembly words 0-3 hold outputs 1-64
// - Words 4-15 hold outputs 65-256, low bit first
// - Words 16-19 hold faults of outputs 1-64
// - Words 20-31 hold faults 65-256, low first
// - Server answers only on TCP port 502
// - Unit identifier zero is never served
// - Status registers readable by codes 04 and 03
// - First eight registers also readable as bits
// - Inputs 10001-10128 give outputs then faults
// - Inputs 11001/12001 give all states and faults
// - Coils 3001-3064 inputs, 4001-4016 reset requests
// - Inputs 15001-15016 give reset/cancel feedback
// - Registers 1-4 states, 5-8 faults
// - Holding registers 9-11 hold soft inputs 1-48
// - Revision 2 and later deny legacy coils
// - Lowest numbered output sits in bit 0
module soft_output_map #(
  parameter int NUM_OUT = soft_output_map_pkg::NUM_OUTPUTS,
  parameter int NUM_RESET = soft_output_map_pkg::NUM_RESET_CANCEL
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request from the network stack
  input wire logic req_valid_i,
  input wire logic [15:0] req_tcp_port_i,
  input wire logic [7:0] req_unit_i,
  input wire logic [7:0] req_func_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  // Answer to the network stack
  output logic resp_valid_o,
  output logic resp_silent_o,
  output logic resp_exc_o,
  output logic [7:0] resp_code_o,
  output logic [15:0] resp_data_o,
  // Extended cyclic assembly read port
  input wire logic [4:0] asm_sel_i,
  output logic [15:0] asm_data_o,
  // Device state, same clock
  input wire logic [255:0] soft_output_i,
  input wire logic [255:0] soft_fault_i,
  input wire logic [15:0] reset_cancel_delay_fb_i,
  input wire logic [7:0] feature_revision_i,
  // Commands toward the safety logic
  output logic [63:0] soft_input_o,
  output logic [15:0] reset_cancel_delay_req_o
);

  // Address map is fixed, so only the documented sizes are served
  if (NUM_OUT != soft_output_map_pkg::NUM_OUTPUTS ||
      NUM_RESET != soft_output_map_pkg::NUM_RESET_CANCEL) begin : g_bad_size
    $error("soft_output_map: sizes are fixed by the address map");
  end

  // Command registers
  logic [63:0] soft_input_r;          // Soft input states
  logic [15:0] reset_req_r;           // Reset/cancel-delay requests
  // Answer registers
  logic resp_valid_r;
  logic resp_silent_r;
  logic resp_exc_r;
  logic [7:0] resp_code_r;
  logic [15:0] resp_data_r;
  logic [15:0] asm_data_r;
  // Next answer values
  logic resp_silent_nxt;
  logic [7:0] resp_code_nxt;
  logic [15:0] resp_data_nxt;
  // Write controls
  logic coil_in_we;                   // Coil write to a soft input
  logic coil_reset_we;                // Coil write to a reset request
  logic reg_we;                       // Register write to a soft input word
  logic [15:0] offs;                  // Address relative to range base
  logic [15:0] status_offs;           // Register number less first status register
  logic [15:0] soft_in_offs;          // Register number less first soft input register
  logic coil_val;                     // Decoded coil level
  // Word views
  logic [15:0] asm_word;
  logic [15:0] status_word;
  logic [15:0] soft_in_word;

  // Word indices straight from the address, so no path loops through the decode
  assign status_offs = req_addr_i - soft_output_map_pkg::REG_STATE_FIRST;
  assign soft_in_offs = req_addr_i - soft_output_map_pkg::REG_SOFT_IN_FIRST;

  // Words 0-3 are the basic outputs
  word_select #(
    .WORDS(soft_output_map_pkg::ASM_WORDS),
    .SEL_W(soft_output_map_pkg::ASM_SEL_W)
  ) u_asm_sel (
    .vec_i({soft_fault_i, soft_output_i}),
    .sel_i(asm_sel_i),
    .word_o(asm_word)
  );

  // Output 1 lands in bit 0
  word_select #(
    .WORDS(8),
    .SEL_W(3)
  ) u_status_sel (
    .vec_i({soft_fault_i[63:0], soft_output_i[63:0]}),
    .sel_i(status_offs[2:0]),
    .word_o(status_word)
  );

  // Soft input word for registers 9-11
  word_select #(
    .WORDS(4),
    .SEL_W(2)
  ) u_soft_in_sel (
    .vec_i(soft_input_r),
    .sel_i(soft_in_offs[1:0]),
    .word_o(soft_in_word)
  );

  // Request decode
  always_comb begin
    resp_silent_nxt = 1'b0;
    resp_code_nxt = soft_output_map_pkg::EXC_BAD_ADDRESS;
    resp_data_nxt = 16'h0000;
    coil_in_we = 1'b0;
    coil_reset_we = 1'b0;
    reg_we = 1'b0;
    offs = 16'h0000;
    coil_val = (req_wdata_i == soft_output_map_pkg::COIL_ON);
    if (req_tcp_port_i != soft_output_map_pkg::SERVER_TCP_PORT ||
        req_unit_i == soft_output_map_pkg::UNIT_ID_REFUSED) begin
      resp_silent_nxt = 1'b1;
      resp_code_nxt = soft_output_map_pkg::EXC_NONE;
    end else if (req_func_i == soft_output_map_pkg::FC_READ_INPUT_REG ||
                 req_func_i == soft_output_map_pkg::FC_READ_HOLDING) begin
      // Same contents for 04 and 03 at registers 1-8; registers 9-11 by 03 only
      if (req_addr_i >= soft_output_map_pkg::REG_STATE_FIRST &&
          req_addr_i <= soft_output_map_pkg::REG_FAULT_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::REG_STATE_FIRST;
        resp_data_nxt = status_word;
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end else if (req_func_i == soft_output_map_pkg::FC_READ_HOLDING &&
                   req_addr_i >= soft_output_map_pkg::REG_SOFT_IN_FIRST &&
                   req_addr_i <= soft_output_map_pkg::REG_SOFT_IN_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::REG_SOFT_IN_FIRST;
        resp_data_nxt = soft_in_word;
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end
    end else if (req_func_i == soft_output_map_pkg::FC_WRITE_REG) begin
      if (req_addr_i >= soft_output_map_pkg::REG_SOFT_IN_FIRST &&
          req_addr_i <= soft_output_map_pkg::REG_SOFT_IN_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::REG_SOFT_IN_FIRST;
        reg_we = 1'b1;
        resp_data_nxt = req_wdata_i;
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end
    end else if (req_func_i == soft_output_map_pkg::FC_READ_DISCRETE) begin
      // Bit view of the status words
      if (req_addr_i >= soft_output_map_pkg::DI_BASIC_FIRST &&
          req_addr_i <= soft_output_map_pkg::DI_BASIC_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::DI_BASIC_FIRST;
        resp_data_nxt = {15'h0000, soft_output_map_bit(offs[6:0])};
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end else if (req_addr_i >= soft_output_map_pkg::DI_STATE_FIRST &&
                   req_addr_i <= soft_output_map_pkg::DI_STATE_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::DI_STATE_FIRST;
        resp_data_nxt = {15'h0000, soft_output_i[offs[7:0]]};
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end else if (req_addr_i >= soft_output_map_pkg::DI_FAULT_FIRST &&
                   req_addr_i <= soft_output_map_pkg::DI_FAULT_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::DI_FAULT_FIRST;
        resp_data_nxt = {15'h0000, soft_fault_i[offs[7:0]]};
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end else if (req_addr_i >= soft_output_map_pkg::DI_FEEDBACK_FIRST &&
                   req_addr_i <= soft_output_map_pkg::DI_FEEDBACK_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::DI_FEEDBACK_FIRST;
        resp_data_nxt = {15'h0000, reset_cancel_delay_fb_i[offs[3:0]]};
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end
    end else if (req_func_i == soft_output_map_pkg::FC_READ_COILS) begin
      // Legacy coils only up to revision 1
      if (feature_revision_i <= soft_output_map_pkg::REV_LEGACY_COILS_MAX &&
          req_addr_i >= soft_output_map_pkg::COIL_BASIC_FIRST &&
          req_addr_i <= soft_output_map_pkg::COIL_BASIC_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::COIL_BASIC_FIRST;
        resp_data_nxt = {15'h0000, soft_output_map_bit(offs[6:0])};
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end
    end else if (req_func_i == soft_output_map_pkg::FC_WRITE_COIL) begin
      // Only the two standard coil values are legal
      if (req_wdata_i != soft_output_map_pkg::COIL_ON &&
          req_wdata_i != soft_output_map_pkg::COIL_OFF) begin
        resp_code_nxt = soft_output_map_pkg::EXC_BAD_VALUE;
      end else if (req_addr_i >= soft_output_map_pkg::COIL_SOFT_IN_FIRST &&
                   req_addr_i <= soft_output_map_pkg::COIL_SOFT_IN_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::COIL_SOFT_IN_FIRST;
        coil_in_we = 1'b1;
        resp_data_nxt = req_wdata_i;
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end else if (req_addr_i >= soft_output_map_pkg::COIL_RESET_FIRST &&
                   req_addr_i <= soft_output_map_pkg::COIL_RESET_LAST) begin
        offs = req_addr_i - soft_output_map_pkg::COIL_RESET_FIRST;
        coil_reset_we = 1'b1;
        resp_data_nxt = req_wdata_i;
        resp_code_nxt = soft_output_map_pkg::EXC_NONE;
      end
    end else begin
      // Unsupported function
      resp_code_nxt = soft_output_map_pkg::EXC_BAD_FUNCTION;
    end
  end

  // Basic bit view: 0-63 states, 64-127 faults
  function automatic logic soft_output_map_bit(input logic [6:0] idx);
    logic [127:0] basic;
    basic = {soft_fault_i[63:0], soft_output_i[63:0]};
    return basic[idx];
  endfunction

  // Soft input state, written by coils or register words
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_input_r <= 64'h0000_0000_0000_0000;
    end else if (req_valid_i && coil_in_we) begin
      soft_input_r[offs[5:0]] <= coil_val;
    end else if (req_valid_i && reg_we) begin
      soft_input_r[offs[1:0]*16 +: 16] <= req_wdata_i;
    end
  end

  // Reset/cancel-delay request bits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_req_r <= 16'h0000;
    end else if (req_valid_i && coil_reset_we) begin
      reset_req_r[offs[3:0]] <= coil_val;
    end
  end

  // Answer, one cycle after the request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_valid_r <= 1'b0;
      resp_silent_r <= 1'b0;
      resp_exc_r <= 1'b0;
      resp_code_r <= 8'h00;
      resp_data_r <= 16'h0000;
    end else begin
      resp_valid_r <= req_valid_i;
      if (req_valid_i) begin
        resp_silent_r <= resp_silent_nxt;
        resp_exc_r <= (resp_code_nxt != soft_output_map_pkg::EXC_NONE);
        resp_code_r <= resp_code_nxt;
        resp_data_r <= resp_data_nxt;
      end
    end
  end

  // Assembly word, registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      asm_data_r <= 16'h0000;
    end else begin
      asm_data_r <= asm_word;
    end
  end

  // Output drive
  assign resp_valid_o = resp_valid_r;
  assign resp_silent_o = resp_silent_r;
  assign resp_exc_o = resp_exc_r;
  assign resp_code_o = resp_code_r;
  assign resp_data_o = resp_data_r;
  assign asm_data_o = asm_data_r;
  assign soft_input_o = soft_input_r;
  assign reset_cancel_delay_req_o = reset_req_r;

  // Checks
  a_unit_zero_silent: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_unit_i == 8'h00 |=> resp_valid_o && resp_silent_o && !resp_exc_o)
    else $error("unit zero request was served");

  a_port_check: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_tcp_port_i != 16'h01f6 |=> resp_silent_o)
    else $error("request on wrong port was served");

  a_asm_word_map: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    asm_sel_i == 5'h04 |=> asm_data_o == $past(soft_output_i[79:64]))
    else $error("assembly word 4 not outputs 65-80");

  a_asm_fault_map: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    asm_sel_i == 5'h14 |=> asm_data_o == $past(soft_fault_i[79:64]))
    else $error("assembly word 20 not faults 65-80");

  a_holding_same: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_tcp_port_i == 16'h01f6 && req_unit_i != 8'h00 &&
    req_func_i == 8'h03 && req_addr_i == 16'h0005
    |=> !resp_exc_o && resp_data_o == $past(soft_fault_i[15:0]))
    else $error("holding register 5 not faults 1-16");

  a_input_reg_nine: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_tcp_port_i == 16'h01f6 && req_unit_i != 8'h00 &&
    req_func_i == 8'h04 && req_addr_i == 16'h0009 |=> resp_exc_o)
    else $error("input register 9 was answered");

  a_fault_bit_read: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_tcp_port_i == 16'h01f6 && req_unit_i != 8'h00 &&
    req_func_i == 8'h02 && req_addr_i == 16'h2751
    |=> resp_data_o[0] == $past(soft_fault_i[0]) && !resp_exc_o)
    else $error("input 10065 not fault of output 1");

  a_coil_sets_input: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_tcp_port_i == 16'h01f6 && req_unit_i != 8'h00 &&
    req_func_i == 8'h05 && req_addr_i == 16'h0bf8 && req_wdata_i == 16'hff00
    |=> soft_input_o[63] ##1 soft_input_o[63] || $past(req_valid_i))
    else $error("coil 3064 did not set input 64");

  a_legacy_coil_deny: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_tcp_port_i == 16'h01f6 && req_unit_i != 8'h00 &&
    req_func_i == 8'h01 && feature_revision_i >= 8'h02 |=> resp_exc_o)
    else $error("legacy coil read allowed on new revision");

endmodule // soft_output_map
`default_nettype wire

// ---- verification/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Network host that hands the map one request per clock
module host_model (
  input wire logic clk_i,
  output logic req_valid_o,
  output logic [15:0] req_tcp_port_o,
  output logic [7:0] req_unit_o,
  output logic [7:0] req_func_o,
  output logic [15:0] req_addr_o,
  output logic [15:0] req_wdata_o
);
  // Quiet bus at time zero
  initial begin
    req_valid_o = 1'b0;
    req_tcp_port_o = 16'h0000;
    req_unit_o = 8'h00;
    req_func_o = 8'h00;
    req_addr_o = 16'h0000;
    req_wdata_o = 16'h0000;
  end
  // any port, unit and code, driven 2 ns after a rising edge
  task automatic send(input logic [15:0] p, input logic [7:0] u, input logic [7:0] f,
                      input logic [15:0] a, input logic [15:0] w);
    @(posedge clk_i);
    #2;
    req_valid_o = 1'b1;
    req_tcp_port_o = p;
    req_unit_o = u;
    req_func_o = f;
    req_addr_o = a;
    req_wdata_o = w;
  endtask
  // Ends a burst; unit, address and write data flip so stale values never look valid
  task automatic idle();
    @(posedge clk_i);
    #2;
    req_valid_o = 1'b0;
    req_unit_o = ~req_unit_o;
    req_addr_o = ~req_addr_o;
    req_wdata_o = ~req_wdata_o;
  endtask
endmodule // host_model
`default_nettype wire

// ---- verification/tb_virtual_output_status_map.sv ----
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the soft output status map
module tb_virtual_output_status_map;
  // Expected answer: kind 0 data, 1 exception, 2 silent
  typedef struct {logic [1:0] k; logic [7:0] c; logic [15:0] d; logic [63:0] si;
                  logic [15:0] rc;} note_t;
  logic clk_i = 1'b0;
  logic rst_n_i;
  logic req_valid_i, resp_valid_o, resp_silent_o, resp_exc_o;
  logic [15:0] req_tcp_port_i, req_addr_i, req_wdata_i, resp_data_o, asm_data_o;
  logic [7:0] req_unit_i, req_func_i, resp_code_o, feature_revision_i;
  logic [4:0] asm_sel_i;
  logic [255:0] soft_output_i, soft_fault_i;
  logic [15:0] reset_cancel_delay_fb_i, reset_cancel_delay_req_o, rc_m;
  logic [63:0] soft_input_o, si_m;
  note_t q[$];
  logic [15:0] aq[$];
  int failures = 0, comparisons = 0, cyc = 0, k, n;
  integer seed;
  logic v;
  logic [15:0] w;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  host_model host (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_tcp_port_o(req_tcp_port_i),
    .req_unit_o(req_unit_i), .req_func_o(req_func_i), .req_addr_o(req_addr_i),
    .req_wdata_o(req_wdata_i));

  soft_output_map DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_tcp_port_i(req_tcp_port_i), .req_unit_i(req_unit_i), .req_func_i(req_func_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .resp_valid_o(resp_valid_o),
    .resp_silent_o(resp_silent_o), .resp_exc_o(resp_exc_o), .resp_code_o(resp_code_o),
    .resp_data_o(resp_data_o), .asm_sel_i(asm_sel_i), .asm_data_o(asm_data_o),
    .soft_output_i(soft_output_i), .soft_fault_i(soft_fault_i),
    .reset_cancel_delay_fb_i(reset_cancel_delay_fb_i), .feature_revision_i(feature_revision_i),
    .soft_input_o(soft_input_o), .reset_cancel_delay_req_o(reset_cancel_delay_req_o));

  // Counts and prints one mismatch
  task automatic fail(input string m);
    failures++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  // Compares one value of up to 64 bits
  task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask
  // Compares a whole answer with its note
  task automatic cmp_resp(input note_t n);
    cmp_word(resp_silent_o, n.k == 2'd2, "silent flag");
    if (n.k != 2'd2) begin
      cmp_word(resp_exc_o, n.k == 2'd1, "exception flag");
      cmp_word(resp_code_o, n.c, "exception code");
      if (n.k == 2'd0) cmp_word(resp_data_o, n.d, "answer data");
    end
    cmp_word(soft_input_o, n.si, "soft inputs");
    cmp_word(reset_cancel_delay_req_o, n.rc, "reset requests");
  endtask
  // Notes the answer, then hands the request to the host
  task automatic rq(input logic [15:0] p, input logic [7:0] u, input logic [7:0] f,
                    input logic [15:0] a, input logic [15:0] wd, input logic [1:0] kd,
                    input logic [7:0] c, input logic [15:0] d);
    q.push_back('{kd, c, d, si_m, rc_m});
    host.send(p, u, f, a, wd);
  endtask
  // Plain good read or write on port 502, unit 1
  task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [15:0] wd,
                    input logic [15:0] d);
    rq(16'h01f6, 8'h01, f, a, wd, 2'd0, 8'h00, d);
  endtask
  // Request expected to end in an exception
  task automatic ex(input logic [7:0] f, input logic [15:0] a, input logic [15:0] wd,
                    input logic [7:0] c);
    rq(16'h01f6, 8'h01, f, a, wd, 2'd1, c, 16'h0000);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watches answers and assembly words, and cuts a hang short
  always @(posedge clk_i) begin
    #1;
    if (resp_valid_o === 1'b1) begin
      if (q.size() == 0) fail("answer without request");
      else cmp_resp(q.pop_front());
    end
    if (aq.size() != 0) cmp_word(asm_data_o, aq.pop_front(), "assembly word");
    cyc++;
    if (cyc > 3000) begin
      fail("timeout");
      finish_test();
    end
  end

  // Main sequence
  initial begin
    seed = 32'ha3d8;
    rst_n_i = 1'b0;
    asm_sel_i = 5'h00;
    feature_revision_i = 8'h02;
    si_m = 64'h0;
    rc_m = 16'h0;
    for (int i = 0; i < 8; i++) begin
      soft_output_i[i*32+:32] = $random(seed);
      soft_fault_i[i*32+:32] = $random(seed);
    end
    reset_cancel_delay_fb_i = $random(seed);
    repeat (5) @(posedge clk_i);
    #2;
    rst_n_i = 1'b1;
    cmp_word(soft_input_o, 64'h0, "reset state");
    cmp_word({48'h0, reset_cancel_delay_req_o}, 64'h0, "reset requests");
    // Every assembly word, outputs then faults
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_i);
      #2;
      asm_sel_i = i[4:0];
      aq.push_back(i < 16 ? soft_output_i[i*16+:16] : soft_fault_i[(i-16)*16+:16]);
    end
    // Registers 1-8 by codes 03 and 04, back to back
    for (int r = 1; r <= 8; r++) begin
      w = r <= 4 ? soft_output_i[(r-1)*16+:16] : soft_fault_i[(r-5)*16+:16];
      rd(8'h03, r[15:0], 16'h0000, w);
      rd(8'h04, r[15:0], 16'h0000, w);
    end
    // Discrete inputs, ends of each range included
    for (int j = 0; j < 8; j++) begin
      k = (j == 0) ? 0 : (j == 7) ? 255 : $unsigned($random(seed)) % 256;
      n = k % 128;
      v = n < 64 ? soft_output_i[n] : soft_fault_i[n-64];
      rd(8'h02, 16'd10001 + n[15:0], 16'h0000, {15'h0, v});
      rd(8'h02, 16'd11001 + k[15:0], 16'h0000, {15'h0, soft_output_i[k]});
      rd(8'h02, 16'd12001 + k[15:0], 16'h0000, {15'h0, soft_fault_i[k]});
      rd(8'h02, 16'd15001 + k[15:0] % 16, 16'h0000, {15'h0, reset_cancel_delay_fb_i[k%16]});
    end
    // First fault bit of the basic view
    rd(8'h02, 16'd10065, 16'h0000, {15'h0, soft_fault_i[0]});
    // Coil writes to soft inputs and reset requests
    for (int j = 0; j < 12; j++) begin
      k = (j == 0) ? 0 : (j == 1) ? 63 : $unsigned($random(seed)) % 64;
      // First two writes switch inputs 1 and 64 on
      v = (j < 2) | $random(seed);
      w = v ? 16'hff00 : 16'h0000;
      si_m[k] = v;
      rd(8'h05, 16'd3001 + k[15:0], w, w);
      rc_m[k%16] = ~v;
      rd(8'h05, 16'd4001 + k[15:0] % 16, ~w & 16'hff00, ~w & 16'hff00);
    end
    ex(8'h05, 16'd3001, 16'h1234, 8'h03);
    ex(8'h07, 16'd1, 16'h0000, 8'h01);
    w = $random(seed);
    si_m[31:16] = w;
    rd(8'h06, 16'd10, w, w);
    for (int r = 0; r < 3; r++) rd(8'h03, 16'd9 + r[15:0], 16'h0000, si_m[r*16+:16]);
    ex(8'h04, 16'd9, 16'h0000, 8'h02);
    ex(8'h06, 16'd8, 16'h0000, 8'h02);
    ex(8'h03, 16'd12, 16'h0000, 8'h02);
    // Dropped requests must not write
    rq(16'h01f7, 8'h01, 8'h04, 16'd1, 16'h0000, 2'd2, 8'h00, 16'h0000);
    rq(16'h01f6, 8'h00, 8'h05, 16'd3001, si_m[0] ? 16'h0000 : 16'hff00, 2'd2, 8'h00,
       16'h0000);
    // Legacy coils only up to revision 1
    ex(8'h01, 16'd1, 16'h0000, 8'h02);
    host.idle();
    feature_revision_i = 8'h01;
    rd(8'h01, 16'd5, 16'h0000, {15'h0, soft_output_i[4]});
    rd(8'h01, 16'd70, 16'h0000, {15'h0, soft_fault_i[5]});
    host.idle();
    feature_revision_i = 8'h00;
    rd(8'h01, 16'd128, 16'h0000, {15'h0, soft_fault_i[63]});
    host.idle();
    // Second reset in mid-run clears the commands
    repeat (2) @(posedge clk_i);
    #2;
    rst_n_i = 1'b0;
    #1;
    cmp_word(soft_input_o, 64'h0, "reset clears");
    cmp_word({48'h0, reset_cancel_delay_req_o}, 64'h0, "reset clears requests");
    @(posedge clk_i);
    #2;
    rst_n_i = 1'b1;
    si_m = 64'h0;
    rc_m = 16'h0;
    rd(8'h04, 16'd4, 16'h0000, soft_output_i[63:48]);
    host.idle();
    repeat (3) @(posedge clk_i);
    if (q.size() != 0) fail("missing answers");
    finish_test();
  end
endmodule // tb_virtual_output_status_map
`default_nettype wire
